/* rtl/sda_pkg.sv */
// Purpose: shared constants and types for the stream delay and advance block
// Assumes: 16-bit register port, 25 MHz system clock
// Notes: one bit period of a stream is split in quarters for delay and sampling
package sda_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int N_STREAMS = 32;
	localparam logic [13:0] BP_DELAY_BASE = 14'h0063;
	localparam logic [13:0] LO_ADV_BASE = 14'h0083;
	localparam logic [13:0] ARRAY_SPAN = 14'h001F;
	localparam logic [15:0] REG_RST = 16'h0000;
	localparam logic [15:0] RDATA_IDLE = 16'h0000;
	// ----------------------------------------------------------------
	// field layout
	// ----------------------------------------------------------------
	localparam int BP_FIELD_MSB = 4;
	localparam int BP_WHOLE_LSB = 2;
	localparam int BP_POINT_MSB = 1;
	localparam int ADV_FIELD_MSB = 1;
	localparam logic [2:0] SAMPLE_DEFAULT_Q = 3'h3;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_NS = 40;
	localparam int FRAME_NS = 125000;
	localparam int FRAME_CYC = FRAME_NS / SYS_CLK_NS;
	localparam logic [11:0] FRAME_LAST = 12'(FRAME_CYC - 1);
	localparam logic [11:0] ADV_STEP_CYC = 12'h002;
	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic ds_n;
		logic rd;
		logic [13:0] addr;
		logic [15:0] wdata;
	} sda_bus_req_t;
	typedef struct packed {
		logic [5:0] delay_q;
		logic [2:0] sample_q;
	} sda_bp_timing_t;
endpackage : sda_pkg

/* rtl/sda_stream_timing.sv */
// Purpose: per-stream backplane input delay/sampling and local output advance
// Assumes: register port sampled on i_sys_clk, frame pulse generated here
// Notes: advance is counted in cycles of i_sys_clk
// Overview of operation
// [RQ1] thirty-two backplane delay registers at consecutive addresses, one per stream
// [RQ2] select low: sample at 3/4 bit, delay equals field quarters, up to 7 3/4
// [RQ3] select high: field bits 4:2 give whole-bit delay zero to seven
// [RQ4] select high: low bits pick sample point 3/4, 4/4, 1/4, 2/4 quarters
// [RQ5] delay fields reset to zero: no delay, sampling at three quarters; o_bp_timing holds sample_q 0 until the first clock after reset
// [RQ6] software writes zeros to unused upper bits of both register kinds
// [RQ7] thirty-two local advance registers at consecutive addresses, streams 0 to 31
// [RQ8] each local output advanced by zero, two, four or six clock cycles
// [RQ9] advance fields reset to zero, giving no output advancement
// [RQ10] advance code 00 none, 01 two, 10 four, 11 six cycles early
// [RQ11] zero advance aligns stream start with the generated frame pulse
// [RQ12] registers read back last write; changes leave other streams untouched
`timescale 1ns/1ns
`default_nettype none
module sda_stream_timing
	import sda_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire sda_bus_req_t i_bus,
	input wire logic i_sample_point_select,
	output logic [15:0] o_rdata,
	output logic o_ack_n,
	output logic o_output_frame_pulse_8m,
	output logic [N_STREAMS-1:0] o_local_serial_output_start,
	output var sda_bp_timing_t [N_STREAMS-1:0] o_bp_timing
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic reg_hit(input logic [13:0] a, input logic [13:0] base);
		return (a >= base) && (a <= base + ARRAY_SPAN);
	endfunction : reg_hit

	function automatic logic [11:0] lead_cyc(input logic [ADV_FIELD_MSB:0] code);
		return ADV_STEP_CYC * {10'h000, code};
	endfunction : lead_cyc

	function automatic sda_bp_timing_t bp_map(input logic sel, input logic [BP_FIELD_MSB:0] f);
		sda_bp_timing_t t;
		t.delay_q = {1'b0, f};
		t.sample_q = SAMPLE_DEFAULT_Q;
		if (sel) begin
			t.delay_q = {1'b0, f[BP_FIELD_MSB:BP_WHOLE_LSB], 2'b00};
			case (f[BP_POINT_MSB:0])
				2'b00: t.sample_q = 3'h3;
				2'b01: t.sample_q = 3'h4;
				2'b10: t.sample_q = 3'h1;
				default: t.sample_q = 3'h2;
			endcase
		end
		return t;
	endfunction : bp_map

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	logic [15:0] bp_delay_r [N_STREAMS];
	logic [15:0] bp_delay_nxt [N_STREAMS];
	logic [15:0] lo_adv_r [N_STREAMS];
	logic [15:0] lo_adv_nxt [N_STREAMS];
	logic busy_r;
	logic busy_nxt;
	logic ack_n_r;
	logic ack_n_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic take;
	logic bp_hit;
	logic lo_hit;
	logic [4:0] bp_idx;
	logic [4:0] lo_idx;
	logic [13:0] bp_off;
	logic [13:0] lo_off;

	always_comb begin
		bp_delay_nxt = bp_delay_r;
		lo_adv_nxt = lo_adv_r;
		rdata_nxt = rdata_r;
		take = !i_bus.cs_n && !i_bus.ds_n && !busy_r;
		// one take per strobe: the master must lift a strobe before the next access
		busy_nxt = (busy_r || take) && !(i_bus.cs_n || i_bus.ds_n);
		ack_n_nxt = !take;
		bp_hit = reg_hit(i_bus.addr, BP_DELAY_BASE);
		lo_hit = reg_hit(i_bus.addr, LO_ADV_BASE);
		bp_off = i_bus.addr - BP_DELAY_BASE;
		lo_off = i_bus.addr - LO_ADV_BASE;
		bp_idx = bp_off[4:0];
		lo_idx = lo_off[4:0];
		if (take) begin
			if (bp_hit) begin
				if (i_bus.rd) begin
					rdata_nxt = bp_delay_r[bp_idx]; // [RQ12]
				end else begin
					bp_delay_nxt[bp_idx] = i_bus.wdata; // [RQ1] [RQ12]
				end
			end else if (lo_hit) begin
				if (i_bus.rd) begin
					rdata_nxt = lo_adv_r[lo_idx]; // [RQ12]
				end else begin
					lo_adv_nxt[lo_idx] = i_bus.wdata; // [RQ7] [RQ12]
				end
			end else if (i_bus.rd) begin
				// unmapped read gives zero; unmapped write leaves read data alone
				rdata_nxt = RDATA_IDLE;
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int i = 0; i < N_STREAMS; i++) begin
				bp_delay_r[i] <= REG_RST; // [RQ5]
				lo_adv_r[i] <= REG_RST; // [RQ9]
			end
			busy_r <= 1'b0;
			ack_n_r <= 1'b1;
			rdata_r <= RDATA_IDLE;
		end else begin
			bp_delay_r <= bp_delay_nxt;
			lo_adv_r <= lo_adv_nxt;
			busy_r <= busy_nxt;
			ack_n_r <= ack_n_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;
	assign o_ack_n = ack_n_r;

	// ----------------------------------------------------------------
	// frame timing and per-stream settings
	// ----------------------------------------------------------------
	logic [11:0] cnt_r;
	logic [11:0] cnt_nxt;
	logic fp_r;
	logic fp_nxt;
	logic [N_STREAMS-1:0] start_r;
	logic [N_STREAMS-1:0] start_nxt;
	sda_bp_timing_t [N_STREAMS-1:0] timing_r;
	sda_bp_timing_t [N_STREAMS-1:0] timing_nxt;

	always_comb begin
		cnt_nxt = (cnt_r == FRAME_LAST) ? 12'h000 : cnt_r + 12'h001;
		fp_nxt = (cnt_r == FRAME_LAST); // [RQ11]
		for (int i = 0; i < N_STREAMS; i++) begin
			// stream start leads the frame pulse by its advance
			start_nxt[i] = (cnt_r ==
				FRAME_LAST - lead_cyc(lo_adv_r[i][ADV_FIELD_MSB:0])); // [RQ8] [RQ10]
			timing_nxt[i] = bp_map(i_sample_point_select,
				bp_delay_r[i][BP_FIELD_MSB:0]); // [RQ2] [RQ3] [RQ4]
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 12'h000;
			fp_r <= 1'b0;
			start_r <= '0;
			timing_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
			fp_r <= fp_nxt;
			start_r <= start_nxt;
			timing_r <= timing_nxt;
		end
	end

	assign o_output_frame_pulse_8m = fp_r;
	assign o_local_serial_output_start = start_r;
	assign o_bp_timing = timing_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic seen_r;
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			seen_r <= 1'b0;
		end else begin
			seen_r <= 1'b1;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_take_write;
		take && !i_bus.rd && bp_hit;
	endsequence

	sequence s_adv_write;
		take && !i_bus.rd && lo_hit;
	endsequence

	a_bp_write_store: assert property ( // [RQ1]
		s_take_write |=> bp_delay_r[$past(bp_idx)] == $past(i_bus.wdata))
		else $error("delay register did not store written value");
	a_adv_write_store: assert property ( // [RQ7]
		s_adv_write |=> lo_adv_r[$past(lo_idx)] == $past(i_bus.wdata))
		else $error("advance register did not store written value");
	a_mode_low_delay: assert property ( // [RQ2]
		!$past(i_sample_point_select) && seen_r |->
		o_bp_timing[0].delay_q == {1'b0, $past(bp_delay_r[0][4:0])} &&
		o_bp_timing[0].sample_q == 3'h3)
		else $error("fractional delay mode wrong");
	a_mode_high_delay: assert property ( // [RQ3]
		$past(i_sample_point_select) && seen_r |->
		o_bp_timing[1].delay_q == {1'b0, $past(bp_delay_r[1][4:2]), 2'b00})
		else $error("integer delay mode wrong");
	a_sample_point: assert property ( // [RQ4]
		$past(i_sample_point_select) && $past(bp_delay_r[2][1:0]) == 2'b10 && seen_r |->
		o_bp_timing[2].sample_q == 3'h1)
		else $error("sample point wrong");
	a_reset_fields: assert property ( // [RQ5] [RQ9]
		!seen_r |-> bp_delay_r[0] == REG_RST && lo_adv_r[31] == REG_RST &&
		o_bp_timing[0].sample_q == 3'h0)
		else $error("fields not cleared by reset");
	a_adv_zero: assert property ( // [RQ11]
		lo_adv_r[0][1:0] == 2'b00 && $stable(lo_adv_r[0]) &&
		o_local_serial_output_start[0] |-> o_output_frame_pulse_8m)
		else $error("zero advance not aligned with frame pulse");
	a_adv_six: assert property ( // [RQ8] [RQ10]
		lo_adv_r[3][1:0] == 2'b11 && $stable(lo_adv_r[3]) && o_local_serial_output_start[3] |->
		!o_output_frame_pulse_8m ##6 o_output_frame_pulse_8m)
		else $error("six cycle advance wrong");
	a_adv_two: assert property ( // [RQ10]
		lo_adv_r[4][1:0] == 2'b01 && $stable(lo_adv_r[4]) && o_local_serial_output_start[4] |->
		##2 o_output_frame_pulse_8m)
		else $error("two cycle advance wrong");
	a_others_stable: assert property ( // [RQ12]
		take && !i_bus.rd && lo_hit && lo_idx != 5'h00 |=> $stable(lo_adv_r[0]))
		else $error("write disturbed another stream");
	a_ack_pulse: assert property ( // [RQ12]
		take |=> !o_ack_n ##1 o_ack_n)
		else $error("acknowledge not a single pulse");
endmodule : sda_stream_timing
`default_nettype wire

/* bench/sda_partner.sv */
// Purpose: receiver model on one local output stream
// Assumes: frame pulse and stream start are one-cycle pulses
// Notes: o_adv gives the cycles from stream start to frame pulse
`timescale 1ns/1ns
`default_nettype none
module sda_partner
	import sda_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_frame,
	input wire logic i_start,
	output logic [7:0] o_adv
);
	logic [7:0] cnt_r;
	// start in the frame cycle itself means no advance
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_r <= 8'hFF;
			o_adv <= 8'hFF;
		end else begin
			cnt_r <= i_start ? 8'h01 : (cnt_r == 8'hFF ? cnt_r : cnt_r + 8'h01);
			if (i_frame) begin
				o_adv <= i_start ? 8'h00 : cnt_r;
			end
		end
	end
endmodule : sda_partner
`default_nettype wire

/* bench/tb_top.sv */
// Purpose: self-checking bench for sda_stream_timing
// Assumes: 25 MHz clock, reset held 6 cycles
// Notes: read data is checked from a queue by the ack monitor
`timescale 1ns/1ns
`default_nettype none
module tb_top
	import sda_pkg::*;
;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic sel_m = 1'h0;
	sda_bus_req_t bus = '{1'h1, 1'h1, 1'h0, 14'h0000, 16'h0000};
	logic [15:0] rdata;
	logic ack_n;
	logic fp;
	logic [31:0] st;
	sda_bp_timing_t [31:0] bpt;
	logic [7:0] adv;
	logic [15:0] expq[$];
	logic [15:0] wv[64];
	logic [8:0] eb;
	logic [31:0] seed = 32'hD1D6;
	int fails = 0;
	int tests_run = 0;
	int s;
	int m;
	int c;
	int sp = 0;
	always #20 clk = ~clk;
	sda_stream_timing dut_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_bus(bus),
		.i_sample_point_select(sel_m), .o_rdata(rdata), .o_ack_n(ack_n),
		.o_output_frame_pulse_8m(fp), .o_local_serial_output_start(st), .o_bp_timing(bpt));
	sda_partner far_u (.i_sys_clk(clk), .i_rst_n(rst_n), .i_frame(fp), .i_start(st[sp]),
		.o_adv(adv));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task automatic acc(input logic r, input logic [13:0] a, input logic [15:0] d);
		int n;
		@(negedge clk);
		bus = '{1'h0, 1'h0, r, a, d};
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (ack_n === 1'h0) break;
		end
		if (n == 8) chk("ack", 16'h0001, 16'h0000);
		@(negedge clk);
		bus.cs_n = 1'h1;
		bus.ds_n = 1'h1;
	endtask : acc
	task automatic rd(input logic [13:0] a, input logic [15:0] e);
		expq.push_back(e);
		acc(1'h1, a, 16'h0000);
	endtask : rd
	task automatic wfp();
		int n;
		for (n = 0; n < 4000; n++) begin
			@(posedge clk);
			if (fp === 1'h1) break;
		end
		if (n == 4000) chk("frame", 16'h0001, 16'h0000);
	endtask : wfp
	task automatic conclude();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : conclude
	// ----------------------------------------------------------------
	// read data monitor
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (ack_n === 1'h0 && bus.rd) begin
			if (expq.size() == 0) chk("queue", 16'h0001, 16'h0000);
			else chk("rdata", rdata, expq.pop_front());
		end
	end
	initial begin
		#(40 * 40000);
		fails++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		@(negedge clk) rst_n = 1'h1;
		@(negedge clk);
		for (s = 0; s < 32; s++) chk("bp_rst", 16'(bpt[s]), 16'h0003);
		// reset values of both arrays, then one unmapped place
		for (s = 0; s < 64; s++) rd(BP_DELAY_BASE + 14'(s), REG_RST);
		rd(14'h00A3, RDATA_IDLE);
		// upper bits kept zero by software
		for (s = 0; s < 64; s++) begin
			wv[s] = 16'(xs()) & (s < 32 ? 16'h001F : 16'h0003);
			// fixed codes on a few streams so the timing checks in the design fire
			if (s == 2) wv[s][1:0] = 2'h2;
			if (s == 32) wv[s] = 16'h0000;
			if (s == 35) wv[s] = 16'h0003;
			if (s == 36) wv[s] = 16'h0001;
			acc(1'h0, BP_DELAY_BASE + 14'(s), wv[s]);
		end
		for (s = 0; s < 64; s++) rd(BP_DELAY_BASE + 14'(s), wv[s]);
		for (m = 0; m < 2; m++) begin
			@(negedge clk) sel_m = m[0];
			repeat (2) @(negedge clk);
			for (s = 0; s < 32; s++) begin
				eb = m[0] ? {1'h0, wv[s][4:2], 2'h0, 3'((wv[s][1:0] + 2) % 4 + 1)}
					: {1'h0, wv[s][4:0], 3'h3};
				chk("bp", 16'(bpt[s]), 16'(eb));
			end
		end
		// streams 0, 3 and 4 keep their fixed advance codes
		sp = 5 + int'(xs() % 27);
		for (c = 0; c < 4; c++) begin
			acc(1'h0, LO_ADV_BASE + 14'(sp), 16'(c));
			wfp();
			wfp();
			@(negedge clk);
			chk("advance", 16'(adv), 16'(2 * c));
		end
		conclude();
	end
endmodule : tb_top
`default_nettype wire
